// *** hdl/dsacc_pkg.sv ***
// dsacc_pkg: constants and types for the dual SAR converter control block
// assumes: one system clock at 250 MHz; host pins are asynchronous to it
package dsacc_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int CFG_W = 12;
    localparam int DAC_W = 10;
    localparam int RES_W = 12;
    localparam logic [11:0] CFG_RESET = 12'h000;
    localparam logic [9:0] DAC_RESET = 10'h3FF;
    localparam logic [11:0] SEQ_RESET = 12'h000;
    localparam logic [11:0] RES_EMPTY = 12'h000;
    // field positions of the control word
    localparam int F_CH_HI = 11;
    localparam int F_CH_LO = 10;
    localparam int F_UE_HI = 9;
    localparam int F_UE_LO = 8;
    localparam int F_DEEP = 7;
    localparam int F_NAP = 6;
    localparam int F_ANAP = 5;
    localparam int F_REFOFF = 4;
    localparam int F_AF_HI = 2;
    localparam int F_AF_LO = 0;
    localparam logic [1:0] UE_ENABLE = 2'h1;
    localparam logic [2:0] AF_DAC_WR = 3'h1;
    localparam logic [2:0] AF_DAC_RD = 3'h3;
    localparam logic [2:0] AF_SEQ_WR = 3'h4;
    localparam logic [2:0] AF_SWRST = 3'h5;
    localparam logic [2:0] AF_SEQ_RD = 3'h6;
    // channel routing codes
    localparam logic [1:0] CH_P0_N0 = 2'h0;
    localparam logic [1:0] CH_N1_N0 = 2'h1;
    localparam logic [1:0] CH_P1_N0 = 2'h2;
    localparam logic [1:0] CH_P1_N1 = 2'h3;
    // converter cycle lengths in converter clocks
    localparam logic [4:0] CONV_CLKS = 5'h0C;
    localparam logic [4:0] PRECH_CLKS = 5'h01;
    localparam logic [4:0] SAMPLE_MIN_CLKS = 5'h02;
    // trigger setup before the sampling converter clock edge
    localparam int TRIG_SETUP_NS = 10;
    localparam int TRIG_SETUP_CYC_INT = (TRIG_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] TRIG_SETUP_CYC = TRIG_SETUP_CYC_INT[1:0];
    typedef enum logic [3:0] {
        ST_ACQ = 4'h1,
        ST_CONV = 4'h2,
        ST_PRECH = 4'h4,
        ST_SAMP = 4'h8
    } dsacc_state_t;
    typedef enum logic [1:0] {
        PEND_NONE = 2'h0,
        PEND_DAC = 2'h1,
        PEND_SEQ = 2'h2
    } dsacc_pend_t;
endpackage

// *** hdl/dsacc_top.sv ***
// dsacc_top: control logic of a dual 12-bit simultaneous-sampling converter
// assumes: host drives trigger, converter clock, chip select and write strobe
// as pins; all are sampled on clk_sys_i through two-stage synchronisers.
// the data bus is held for several system clocks around the write strobe.
// software reset loads every register's power-on image; trigger, state-machine and read updates of that same clock still apply over it.
`timescale 1ns/1ns
`default_nettype none
module dsacc_top (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic conversion_trigger_n_i,
    input wire logic conv_clk_i,
    input wire logic chip_select_n_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic [dsacc_pkg::CFG_W-1:0] parallel_data_bus_i,
    input wire logic [dsacc_pkg::RES_W-1:0] sar_result_a_i,
    input wire logic [dsacc_pkg::RES_W-1:0] sar_result_b_i,
    output logic busy_o,
    output logic hold_o,
    output logic precharge_o,
    output logic [1:0] channel_select_o,
    output logic [dsacc_pkg::DAC_W-1:0] ref_dac_code_o,
    output logic deep_sleep_o,
    output logic nap_o,
    output logic auto_nap_o,
    output logic reference_off_o,
    output logic [dsacc_pkg::CFG_W-1:0] sequencer_word_o,
    output logic [dsacc_pkg::RES_W-1:0] result_a_o,
    output logic [dsacc_pkg::RES_W-1:0] result_b_o,
    output logic result_valid_o
);
    import dsacc_pkg::*;

    typedef struct packed {
        logic [2:0] trig_sy;
        logic [2:0] cclk_sy;
        logic [1:0] cs_sy;
        logic [2:0] wr_sy;
        logic [2:0] rd_sy;
        logic [CFG_W-1:0] db_s1;
        logic [CFG_W-1:0] db_s2;
        logic [1:0] trig_age;
        logic trig_armed;
        logic [CFG_W-1:0] cfg;
        logic [DAC_W-1:0] dac;
        logic [CFG_W-1:0] seq;
        dsacc_pend_t pend;
        logic pd_arm;
        logic deep;
        logic nap;
        logic anap;
        logic [1:0] chan;
        dsacc_state_t st;
        logic [4:0] cnt;
        logic prech;
        logic busy;
        logic hold;
        logic [RES_W-1:0] res_a;
        logic [RES_W-1:0] res_b;
        logic res_full;
        logic [RES_W-1:0] out_a;
        logic [RES_W-1:0] out_b;
        logic out_v;
    } dsacc_regs_t;

    dsacc_regs_t r_r;
    dsacc_regs_t r_nxt;

    // rising edge from a synchroniser history, never looking at stage one
    function automatic logic rise(input logic [2:0] h);
        return h[1] & ~h[2];
    endfunction

    function automatic logic fall(input logic [2:0] h);
        return ~h[1] & h[2];
    endfunction

    // one more pin sample into a synchroniser history
    function automatic logic [2:0] shift_in(input logic [2:0] h, input logic pin);
        return {h[1:0], pin};
    endfunction

    // counter step shared by the sequencer states
    function automatic logic [4:0] cnt_next(input logic [4:0] c);
        return c + 5'h01;
    endfunction

    // power-on and software-reset image of every register
    localparam dsacc_regs_t REGS_RESET = '{
        trig_sy: 3'h7, cclk_sy: 3'h0, cs_sy: 2'h3,
        wr_sy: 3'h7, rd_sy: 3'h7,
        db_s1: 12'h000, db_s2: 12'h000,
        trig_age: 2'h0, trig_armed: 1'b0,
        cfg: CFG_RESET, dac: DAC_RESET,
        seq: SEQ_RESET, pend: PEND_NONE,
        pd_arm: 1'b0,
        deep: 1'b0, nap: 1'b0, anap: 1'b0,
        chan: CH_P0_N0,
        st: ST_ACQ, cnt: 5'h00, prech: 1'b0,
        busy: 1'b0, hold: 1'b0,
        res_a: RES_EMPTY, res_b: RES_EMPTY,
        res_full: 1'b0,
        out_a: RES_EMPTY, out_b: RES_EMPTY, out_v: 1'b0
    };

    logic wr_edge;
    logic cclk_edge;
    logic rd_edge;
    logic [CFG_W-1:0] db;
    logic upd_en;
    logic [2:0] afn;
    // last conversion clock of the running conversion
    logic conv_end;

    always_comb begin
        r_nxt = r_r;
        // synchronisers: stage one feeds stage two only
        r_nxt.trig_sy = shift_in(r_r.trig_sy, conversion_trigger_n_i);
        r_nxt.cclk_sy = shift_in(r_r.cclk_sy, conv_clk_i);
        r_nxt.cs_sy = {r_r.cs_sy[0], chip_select_n_i};
        r_nxt.wr_sy = shift_in(r_r.wr_sy, write_strobe_n_i);
        r_nxt.rd_sy = shift_in(r_r.rd_sy, read_strobe_n_i);
        // data pins pass two stages too; the host holds them past the strobe
        r_nxt.db_s1 = parallel_data_bus_i;
        r_nxt.db_s2 = r_r.db_s1;
        db = r_r.db_s2;
        wr_edge = rise(r_r.wr_sy) & ~r_r.cs_sy[1];
        rd_edge = fall(r_r.rd_sy) & ~r_r.cs_sy[1];
        cclk_edge = rise(r_r.cclk_sy);
        // field positions of the incoming word
        upd_en = (db[F_UE_HI:F_UE_LO] == UE_ENABLE);
        afn = db[F_AF_HI:F_AF_LO];
        conv_end = (r_r.st == ST_CONV) && cclk_edge && (cnt_next(r_r.cnt) == CONV_CLKS);

        if (wr_edge) begin
            // power-down armed by previous word applies now
            if (r_r.pd_arm) begin
                r_nxt.deep = r_r.cfg[F_DEEP];
                r_nxt.nap = r_r.cfg[F_NAP];
                r_nxt.anap = r_r.cfg[F_ANAP];
                r_nxt.pd_arm = 1'b0;
            end
            if (r_r.pend == PEND_DAC) begin
                // second access carries the DAC code
                r_nxt.dac = db[DAC_W-1:0];
                r_nxt.pend = PEND_NONE;
            end else if (r_r.pend == PEND_SEQ) begin
                r_nxt.seq = db;
                r_nxt.pend = PEND_NONE;
            end else begin
                r_nxt.cfg = db;
                r_nxt.pd_arm = 1'b1;
                r_nxt.chan = db[F_CH_HI:F_CH_LO];
                // update enable gates the follow-up access
                if (upd_en) begin
                    case (afn)
                        AF_DAC_WR: r_nxt.pend = PEND_DAC;
                        AF_SEQ_WR: r_nxt.pend = PEND_SEQ;
                        AF_SWRST: r_nxt = REGS_RESET;
                        default: r_nxt.pend = PEND_NONE;
                    endcase
                end
            end
        end

        // trigger fall holds inputs; setup counted before next clock edge
        if (fall(r_r.trig_sy) && !r_r.busy) begin
            r_nxt.hold = 1'b1;
            r_nxt.trig_armed = 1'b1;
            r_nxt.trig_age = 2'h0;
        end else if (r_r.trig_armed && r_r.trig_age != TRIG_SETUP_CYC) begin
            r_nxt.trig_age = r_r.trig_age + 2'h1;
        end

        case (r_r.st)
            ST_ACQ: begin
                r_nxt.busy = 1'b0;
                if (cclk_edge && r_r.trig_armed && r_r.trig_age == TRIG_SETUP_CYC) begin
                    r_nxt.busy = 1'b1;
                    r_nxt.trig_armed = 1'b0;
                    r_nxt.st = ST_CONV;
                    r_nxt.cnt = 5'h00;
                end
            end
            ST_CONV: begin
                if (cclk_edge) begin
                    r_nxt.cnt = cnt_next(r_r.cnt);
                end
                if (conv_end) begin
                    r_nxt.busy = 1'b0;
                    r_nxt.prech = 1'b1;
                    r_nxt.res_a = sar_result_a_i;
                    r_nxt.res_b = sar_result_b_i;
                    r_nxt.res_full = 1'b1;
                    r_nxt.st = ST_PRECH;
                    r_nxt.cnt = 5'h00;
                end
            end
            ST_PRECH: begin
                if (cclk_edge) begin
                    r_nxt.cnt = cnt_next(r_r.cnt);
                    if (cnt_next(r_r.cnt) == PRECH_CLKS) begin
                        // a trigger taken during precharge keeps the inputs held
                        r_nxt.hold = r_r.trig_armed | fall(r_r.trig_sy);
                        r_nxt.prech = 1'b0;
                        r_nxt.st = ST_SAMP;
                        r_nxt.cnt = 5'h00;
                    end
                end
            end
            ST_SAMP: begin
                if (cclk_edge) begin
                    r_nxt.cnt = cnt_next(r_r.cnt);
                    if (cnt_next(r_r.cnt) == SAMPLE_MIN_CLKS) begin
                        r_nxt.st = ST_ACQ;
                        r_nxt.cnt = 5'h00;
                    end
                end
            end
            default: begin
                r_nxt.st = ST_ACQ;
                r_nxt.busy = 1'b0;
                r_nxt.prech = 1'b0;
            end
        endcase

        // one read per result, later reads give 000
        r_nxt.out_v = 1'b0;
        if (rd_edge) begin
            r_nxt.out_v = 1'b1;
            r_nxt.out_a = r_r.res_full ? r_r.res_a : RES_EMPTY;
            r_nxt.out_b = r_r.res_full ? r_r.res_b : RES_EMPTY;
            // set wins: a result landing on the read edge stays fresh
            if (!conv_end) begin
                r_nxt.res_full = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            r_r <= REGS_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign busy_o = r_r.busy;
    assign hold_o = r_r.hold;
    // precharge level from its own flop
    assign precharge_o = r_r.prech;
    assign channel_select_o = r_r.chan;
    assign ref_dac_code_o = r_r.dac;
    assign deep_sleep_o = r_r.deep;
    assign nap_o = r_r.nap;
    assign auto_nap_o = r_r.anap;
    assign reference_off_o = r_r.cfg[F_REFOFF];
    assign sequencer_word_o = r_r.seq;
    assign result_a_o = r_r.out_a;
    assign result_b_o = r_r.out_b;
    assign result_valid_o = r_r.out_v;
endmodule
`default_nettype wire

// *** dv/dsacc_properties.sv ***
// dsacc_properties: port assertions for dsacc_top
// assumes: 8 system clocks per converter clock
`timescale 1ns/1ns
`default_nettype none
module dsacc_properties (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic write_strobe_n_i,
    input wire logic busy_o,
    input wire logic hold_o,
    input wire logic precharge_o,
    input wire logic [1:0] channel_select_o,
    input wire logic [dsacc_pkg::DAC_W-1:0] ref_dac_code_o,
    input wire logic result_valid_o
);
    import dsacc_pkg::*;
    logic [3:0] since_wr_r;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            since_wr_r <= 4'hF;
        end else if (!write_strobe_n_i) begin
            since_wr_r <= 4'h0;
        end else if (since_wr_r != 4'hF) begin
            since_wr_r <= since_wr_r + 4'h1;
        end
    end
    a_busy_after_hold: assert property ($rose(busy_o) |-> $past(hold_o))
        else $error("busy rose without hold");
    a_busy_min_span: assert property ($rose(busy_o) |-> busy_o[*8])
        else $error("busy dropped early");
    a_prech_after_busy: assert property ($fell(busy_o) |-> precharge_o)
        else $error("no precharge after busy");
    a_prech_one_clock: assert property ($rose(precharge_o) |-> precharge_o[*7] ##[1:3] !precharge_o)
        else $error("precharge length wrong");
    a_acq_busy_low: assert property (precharge_o || !hold_o |-> !busy_o)
        else $error("busy high in acquisition");
    a_dac_after_reset: assert property ($fell(rst_i) |-> ref_dac_code_o == DAC_RESET)
        else $error("dac code not at reset value");
    a_valid_single: assert property (result_valid_o |=> !result_valid_o)
        else $error("valid longer than one cycle");
    a_chan_on_strobe: assert property ($changed(channel_select_o) |-> since_wr_r < 4'h8)
        else $error("channel changed without strobe");
endmodule
bind dsacc_top dsacc_properties i_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .write_strobe_n_i(write_strobe_n_i), .busy_o(busy_o), .hold_o(hold_o), .precharge_o(precharge_o),
    .channel_select_o(channel_select_o), .ref_dac_code_o(ref_dac_code_o), .result_valid_o(result_valid_o));
`default_nettype wire

// *** dv/dsacc_host.sv ***
// dsacc_host: host model for trigger, converter clock and bus pins
// assumes: tasks are entered at falling system clock edges
`timescale 1ns/1ns
`default_nettype none
module dsacc_host (
    input wire logic clk_sys_i,
    input wire logic busy_o,
    output logic trig_n_o,
    output logic cclk_o,
    output logic cs_n_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic [11:0] data_o
);
    initial begin
        trig_n_o = 1'b1;
        cclk_o = 1'b0;
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        data_o = 12'h000;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // converter clock stays parked low across register writes
    task automatic wr_word(input logic cs_n, input logic [11:0] w);
        cs_n_o = cs_n;
        data_o = w;
        wr_n_o = 1'b0;
        idle(4);
        wr_n_o = 1'b1;
        idle(4);
        cs_n_o = 1'b1;
        // a released bus does not keep its last word
        data_o = ~w;
        idle(8);
    endtask
    task automatic rd_pulse();
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        idle(4);
        rd_n_o = 1'b1;
        idle(4);
        cs_n_o = 1'b1;
        idle(4);
    endtask
    task automatic convert();
        while (busy_o !== 1'b0) idle(1);
        trig_n_o = 1'b0;
        idle(8);
        // sixteen 32 ns clocks, parked low
        for (int i = 0; i < 16; i++) begin
            cclk_o = 1'b1;
            idle(4);
            cclk_o = 1'b0;
            trig_n_o = 1'b1;
            idle(4);
        end
    endtask
endmodule
`default_nettype wire

// *** dv/dsacc_top_bench.sv ***
// dsacc_top_bench: self-checking bench for dsacc_top
// assumes: dsacc_host drives the host pins
`timescale 1ns/1ns
`default_nettype none
module dsacc_top_bench;
    import dsacc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic conversion_trigger_n_i, conv_clk_i, chip_select_n_i, write_strobe_n_i, read_strobe_n_i;
    logic [11:0] parallel_data_bus_i, sar_result_a_i, sar_result_b_i, sequencer_word_o, result_a_o, result_b_o;
    logic [9:0] ref_dac_code_o, d;
    logic [1:0] channel_select_o;
    logic busy_o, hold_o, precharge_o, deep_sleep_o, nap_o, auto_nap_o, reference_off_o, result_valid_o;
    logic [11:0] m_cfg = 12'h000;
    logic [11:0] exp_cfg = 12'h000;
    logic [2:0] m_pd;
    logic [23:0] q[$];
    logic [23:0] e;
    int err_count = 0;
    int total_checks = 0;
    int seed = 89541;
    int n_busy = 0;
    int n_valid = 0;
    int n;
    wire logic [11:0] cfg_seen = {channel_select_o, 2'h0, deep_sleep_o, nap_o, auto_nap_o, reference_off_o, 4'h0};
    dsacc_top i_dut (.clk_sys_i, .rst_i, .conversion_trigger_n_i, .conv_clk_i, .chip_select_n_i, .write_strobe_n_i,
        .read_strobe_n_i, .parallel_data_bus_i, .sar_result_a_i, .sar_result_b_i, .busy_o, .hold_o, .precharge_o,
        .channel_select_o, .ref_dac_code_o, .deep_sleep_o, .nap_o, .auto_nap_o, .reference_off_o, .sequencer_word_o,
        .result_a_o, .result_b_o, .result_valid_o);
    dsacc_host i_host (.clk_sys_i, .busy_o, .trig_n_o(conversion_trigger_n_i), .cclk_o(conv_clk_i),
        .cs_n_o(chip_select_n_i), .wr_n_o(write_strobe_n_i), .rd_n_o(read_strobe_n_i), .data_o(parallel_data_bus_i));
    always #2 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i) n_busy += (busy_o === 1'b1);
    always @(negedge clk_sys_i) n_valid += (result_valid_o === 1'b1);
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // power-down bits come from the word before the latest write
    task automatic cfg_wr(input logic [11:0] w);
        i_host.wr_word(1'b0, w);
        m_pd = m_cfg[7:5];
        m_cfg = w;
        exp_cfg = {w[11:10], 2'h0, m_pd, w[4], 4'h0};
        check("config", cfg_seen, exp_cfg);
    endtask
    initial begin
        #40000;
        err_count++;
        finish_test();
    end
    initial begin
        sar_result_a_i = 12'h000;
        sar_result_b_i = 12'h000;
        repeat (6) @(negedge clk_sys_i);
        rst_i = 1'b0;
        i_host.idle(4);
        check("dac", {2'h0, ref_dac_code_o}, {2'h0, DAC_RESET});
        check("config", cfg_seen, CFG_RESET);
        $display("reset done");
        for (int i = 0; i < 8; i++) begin
            cfg_wr({i[1:0], UE_ENABLE, 4'($random(seed)), 4'h0});
        end
        cfg_wr(CFG_RESET);
        cfg_wr(CFG_RESET);
        i_host.wr_word(1'b1, 12'hDF0);
        check("deselected", cfg_seen, exp_cfg);
        $display("config done");
        d = 10'h0CD + 10'({$random(seed)} % 32'h333);
        cfg_wr({2'h0, UE_ENABLE, 5'h00, AF_DAC_WR});
        // code kept at 205 or above
        i_host.wr_word(1'b0, {2'h0, d});
        check("dac", {2'h0, ref_dac_code_o}, {2'h0, d});
        cfg_wr({2'h1, 2'h3, 5'h00, AF_DAC_WR});
        cfg_wr({2'h2, 2'h0, 8'h00});
        check("dac kept", {2'h0, ref_dac_code_o}, {2'h0, d});
        cfg_wr({2'h3, UE_ENABLE, 5'h00, AF_SEQ_WR});
        e = 24'($random(seed));
        i_host.wr_word(1'b0, e[11:0]);
        check("sequencer", sequencer_word_o, e[11:0]);
        $display("paired writes done");
        for (int i = 0; i < 3; i++) begin
            sar_result_a_i = 12'($random(seed));
            sar_result_b_i = 12'($random(seed));
            q.push_back({sar_result_a_i, sar_result_b_i});
            n = n_busy;
            i_host.convert();
            check("busy cycles", 12'(n_busy - n), 12'h060);
            n = n_valid;
            i_host.rd_pulse();
            check("valid pulses", 12'(n_valid - n), 12'h001);
            e = q.pop_front();
            check("result a", result_a_o, e[23:12]);
            check("result b", result_b_o, e[11:0]);
            i_host.rd_pulse();
            check("reread", result_a_o | result_b_o, RES_EMPTY);
        end
        $display("conversions done");
        i_host.wr_word(1'b0, {2'h3, UE_ENABLE, 5'h00, AF_SWRST});
        check("dac", {2'h0, ref_dac_code_o}, {2'h0, DAC_RESET});
        check("config", cfg_seen, CFG_RESET);
        check("sequencer", sequencer_word_o, SEQ_RESET);
        $display("soft reset done");
        finish_test();
    end
endmodule
`default_nettype wire
